// >>> hdl/chpna_host_port.sv
// Contract
// - 16-bit data bus; device drives it only during host reads.
// - write data taken at first rise of write or select while both low.
// - handshake falls when access recognised, rises when access completes.
// - byte-order pin low inverts internal address bit 0.
// - internal-select pin low makes the arbiter enable internally.
// - buffer RAM bytes travel on an 8-bit two-way bus.
// - buffer RAM addressed by an 11-bit address output.
// - input area 100H, output area 080H, plus twice the node number.
`timescale 1ns/10ps
`default_nettype none
module chpna_host_port
   import chpna_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] host_addr_pins,
   input wire logic [DATA_W-1:0] host_data_pins_in,
   output logic [DATA_W-1:0] host_data_pins_out,
   output logic host_data_pins_oe_n,
   input wire logic host_select_n,
   input wire logic host_read_n,
   input wire logic host_write_n,
   output logic access_handshake,
   input wire logic byte_order_invert_n,
   input wire logic arbiter_enable_n,
   input wire logic arbiter_internal_sel_n,
   output logic [ADDR_W-1:0] ram_addr_pins,
   input wire logic [BYTE_W-1:0] ram_data_pins_in,
   output logic [BYTE_W-1:0] ram_data_pins_out,
   output logic ram_data_pins_oe_n,
   output logic ramRd_n,
   output logic ramWr_n,
   input wire logic scanEnable,
   input wire logic replyValid,
   input wire logic [NODE_W-1:0] replyNode,
   input wire logic [DATA_W-1:0] replyData,
   output logic cmdValid,
   output logic [NODE_W-1:0] cmdNode,
   output logic [CMD_W-1:0] cmdCode,
   output logic [DATA_W-1:0] cmdData
);
   chpna_ram_if ram ();
   chpna_host_e hst_r;
   chpna_scan_e scn_r;
   logic [DATA_W-1:0] wd_r;
   logic [BYTE_W-1:0] rdLo_r;
   logic owner_r;
   logic [NODE_W-1:0] node_r;
   logic [DATA_W-1:0] ctlWord_r;
   logic [DATA_W-1:0] outWord_r;
   logic repPend_r;
   logic [NODE_W-1:0] repNode_r;
   logic [DATA_W-1:0] repData_r;
   logic relSeen_r;

   // ***********************************************
   // host strobe decode and byte addressing
   // ***********************************************
   logic rdReq, wrBoth, anyStrobe, swapBit;
   logic hostWant, hostWe, hostHi, hostDone, hostRdDone;
   logic [ADDR_W-1:0] hostAddr;
   logic [BYTE_W-1:0] hostWdata;
   assign rdReq = ~host_select_n & ~host_read_n;
   assign wrBoth = ~host_select_n & ~host_write_n;
   assign anyStrobe = ~host_select_n & (~host_read_n | ~host_write_n);
   assign swapBit = ~byte_order_invert_n;
   assign hostWant = (hst_r == H_WR0) | (hst_r == H_WR1)
                   | (hst_r == H_RD0) | (hst_r == H_RD1);
   assign hostWe = (hst_r == H_WR0) | (hst_r == H_WR1);
   assign hostHi = (hst_r == H_WR1) | (hst_r == H_RD1);
   // address pins are used live; the host holds them through the access
   assign hostAddr = {host_addr_pins[ADDR_W-1:1], swapBit ^ hostHi};
   assign hostWdata = hostHi ? wd_r[DATA_W-1:BYTE_W] : wd_r[BYTE_W-1:0];
   assign hostDone = ram.done & ~owner_r;
   assign hostRdDone = hostDone & (hst_r == H_RD1);

   // ***********************************************
   // scan engine addressing
   // ***********************************************
   logic scanWant, scanWe, scanHi, scanDone, isCtl, isOut;
   logic [ADDR_W-1:0] scanBase, scanAddr;
   logic [NODE_W-1:0] scanNode;
   logic [BYTE_W-1:0] scanWdata;
   assign isCtl = (scn_r == S_CTL0) | (scn_r == S_CTL1);
   assign isOut = (scn_r == S_OUT0) | (scn_r == S_OUT1);
   assign scanWe = (scn_r == S_REP0) | (scn_r == S_REP1);
   assign scanWant = isCtl | isOut | scanWe;
   assign scanHi = (scn_r == S_CTL1) | (scn_r == S_OUT1)
                 | (scn_r == S_REP1);
   assign scanBase = isCtl ? CTRL_BASE : (isOut ? OUT_BASE : IN_BASE);
   assign scanNode = scanWe ? repNode_r : node_r;
   assign scanAddr = scanBase | {NODE_PAD, scanNode, scanHi};
   assign scanWdata = scanHi ? repData_r[DATA_W-1:BYTE_W]
                             : repData_r[BYTE_W-1:0];
   assign scanDone = ram.done & owner_r;

   // ***********************************************
   // arbiter: host first while enabled, else scan first
   // ***********************************************
   logic arbEn, startHost, startScan;
   assign arbEn = arbiter_internal_sel_n ? ~arbiter_enable_n : 1'b1;
   assign startHost = ram.ready & hostWant & (arbEn | ~scanWant);
   assign startScan = ram.ready & scanWant & ~startHost;
   assign ram.req = startHost | startScan;
   assign ram.we = startHost ? hostWe : scanWe;
   assign ram.addr = startHost ? hostAddr : scanAddr;
   assign ram.wdata = startHost ? hostWdata : scanWdata;

   chpna_ram_port u_ram (
      .core_clk(core_clk),
      .rstn(rstn),
      .ram(ram.slave),
      .ram_addr_pins(ram_addr_pins),
      .ram_data_pins_in(ram_data_pins_in),
      .ram_data_pins_out(ram_data_pins_out),
      .ram_data_pins_oe_n(ram_data_pins_oe_n),
      .ramRd_n(ramRd_n),
      .ramWr_n(ramWr_n)
   );

   // ***********************************************
   // host access sequencer
   // ***********************************************
   chpna_host_e hst_nxt;
   always_comb begin
      hst_nxt = hst_r;
      case (hst_r)
         H_IDLE: begin
            // wait for full release so one access is never taken twice
            if (access_handshake && relSeen_r && rdReq) hst_nxt = H_RD0;
            else if (access_handshake && relSeen_r && wrBoth) hst_nxt = H_WCAP;
         end
         H_WCAP: if (!wrBoth) hst_nxt = H_WR0;
         H_WR0: if (hostDone) hst_nxt = H_WR1;
         H_WR1: if (hostDone) hst_nxt = H_IDLE;
         H_RD0: if (hostDone) hst_nxt = H_RD1;
         H_RD1: if (hostDone) hst_nxt = H_IDLE;
         default: hst_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         hst_r <= H_IDLE;
         wd_r <= '0;
         rdLo_r <= '0;
         access_handshake <= 1'b1;
         host_data_pins_out <= '0;
         host_data_pins_oe_n <= 1'b1;
         owner_r <= 1'b0;
         relSeen_r <= 1'b1;
      end else begin
         hst_r <= hst_nxt;
         relSeen_r <= (hst_r == H_IDLE) & (relSeen_r | ~anyStrobe);
         if (startHost | startScan) owner_r <= startScan;
         if (hst_r == H_WCAP && wrBoth) wd_r <= host_data_pins_in;
         if (hostDone && hst_r == H_RD0) rdLo_r <= ram.rdata;
         if (hst_r == H_IDLE && hst_nxt != H_IDLE) begin
            access_handshake <= 1'b0;
         end else if ((hostDone && hst_r == H_WR1) || hostRdDone) begin
            access_handshake <= 1'b1;
         end
         if (hostRdDone) begin
            host_data_pins_out <= {ram.rdata, rdLo_r};
            host_data_pins_oe_n <= 1'b0;
         end else if (!rdReq) begin
            host_data_pins_oe_n <= 1'b1;
         end
      end
   end

   // ***********************************************
   // node scan: control word, output word, send, reply
   // ***********************************************
   chpna_scan_e scn_nxt;
   always_comb begin
      scn_nxt = scn_r;
      case (scn_r)
         S_IDLE: if (scanEnable) scn_nxt = S_CTL0;
         S_CTL0: if (scanDone) scn_nxt = S_CTL1;
         S_CTL1: if (scanDone) scn_nxt = S_OUT0;
         S_OUT0: if (scanDone) scn_nxt = S_OUT1;
         S_OUT1: if (scanDone) scn_nxt = S_SEND;
         S_SEND: begin
            if (repPend_r) scn_nxt = S_REP0;
            else if (scanEnable) scn_nxt = S_CTL0;
            else scn_nxt = S_IDLE;
         end
         S_REP0: if (scanDone) scn_nxt = S_REP1;
         S_REP1: if (scanDone) scn_nxt = scanEnable ? S_CTL0 : S_IDLE;
         default: scn_nxt = S_IDLE;
      endcase
   end

   logic repClr, repTake;
   assign repClr = scanDone & (scn_r == S_REP1);
   // a reply is not restaged while its bytes are being written
   assign repTake = replyValid & ~scanWe;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         scn_r <= S_IDLE;
         node_r <= '0;
         ctlWord_r <= '0;
         outWord_r <= '0;
         repPend_r <= 1'b0;
         repNode_r <= '0;
         repData_r <= '0;
         cmdValid <= 1'b0;
         cmdNode <= '0;
         cmdCode <= '0;
         cmdData <= '0;
      end else begin
         scn_r <= scn_nxt;
         if (scanDone && scn_r == S_CTL0) ctlWord_r[BYTE_W-1:0] <= ram.rdata;
         if (scanDone && scn_r == S_CTL1) begin
            ctlWord_r[DATA_W-1:BYTE_W] <= ram.rdata;
         end
         if (scanDone && scn_r == S_OUT0) outWord_r[BYTE_W-1:0] <= ram.rdata;
         if (scanDone && scn_r == S_OUT1) begin
            outWord_r[DATA_W-1:BYTE_W] <= ram.rdata;
         end
         if (repTake) begin
            repPend_r <= 1'b1;
            repNode_r <= replyNode;
            repData_r <= replyData;
         end else if (repClr) begin
            repPend_r <= 1'b0;
         end
         cmdValid <= (scn_r == S_SEND);
         if (scn_r == S_SEND) begin
            cmdNode <= node_r;
            cmdCode <= ctlWord_r[CMD_LSB +: CMD_W];
            cmdData <= outWord_r;
            node_r <= node_r + NODE_STEP;
         end
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   a_ack_falls_start: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (hst_r == H_IDLE && access_handshake && relSeen_r && anyStrobe)
      |=> !access_handshake)
      else $error("handshake did not fall on recognised access");
   a_ack_rises_done: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (hostDone && (hst_r == H_WR1 || hst_r == H_RD1))
      |=> access_handshake && hst_r == H_IDLE)
      else $error("handshake did not rise at completion");
   a_wr_data_capture: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (hst_r == H_WCAP && wrBoth) ##1 !wrBoth
      |-> wd_r == $past(host_data_pins_in, 1))
      else $error("write data not the last value before the rise");
   a_drive_read_only: assert property (
      @(posedge core_clk) disable iff (!rstn)
      $fell(host_data_pins_oe_n) |-> $past(hostRdDone) && $past(rdReq))
      else $error("host data driven outside a read");
   a_swap_low_byte: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (startHost && (hst_r == H_WR0 || hst_r == H_RD0))
      |-> ram.addr[0] == ~byte_order_invert_n)
      else $error("low byte address bit 0 ignores byte order");
   a_arb_internal: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (!arbiter_internal_sel_n && ram.ready && hostWant) |-> startHost)
      else $error("internal arbiter enable did not grant host");
   a_cmd_from_ctrl: assert property (
      @(posedge core_clk) disable iff (!rstn)
      cmdValid |-> cmdCode == $past(ctlWord_r[CMD_LSB +: CMD_W])
                   && cmdData == $past(outWord_r))
      else $error("command packet does not carry control word");
   a_in_area_addr: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (startScan && scn_r == S_REP0)
      |-> ram.addr == (IN_BASE | {NODE_PAD, repNode_r, 1'b0})
      ##[1:3] scanDone)
      else $error("reply written outside its input area slot");
endmodule
`default_nettype wire

// >>> hdl/chpna_pkg.sv
package chpna_pkg;
   // ***********************************************
   // widths
   // ***********************************************
   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int NODE_W = 6;
   localparam int CMD_W = 4;
   localparam int CMD_LSB = 0;
   // ***********************************************
   // buffer RAM areas, byte addresses, two bytes per node
   // ***********************************************
   localparam logic [ADDR_W-1:0] CTRL_BASE = 11'h000;
   localparam logic [ADDR_W-1:0] OUT_BASE = 11'h080;
   localparam logic [ADDR_W-1:0] IN_BASE = 11'h100;
   localparam logic [3:0] NODE_PAD = 4'h0;
   localparam logic [NODE_W-1:0] NODE_STEP = 6'h01;
   // ***********************************************
   // reset: surrounding logic holds rstn low at least this long
   // ***********************************************
   localparam int RESET_MIN_CLKS = 10;
   // ***********************************************
   // state encodings
   // ***********************************************
   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_WCAP = 6'h02,
      H_WR0 = 6'h04,
      H_WR1 = 6'h08,
      H_RD0 = 6'h10,
      H_RD1 = 6'h20
   } chpna_host_e;
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_CTL0 = 8'h02,
      S_CTL1 = 8'h04,
      S_OUT0 = 8'h08,
      S_OUT1 = 8'h10,
      S_SEND = 8'h20,
      S_REP0 = 8'h40,
      S_REP1 = 8'h80
   } chpna_scan_e;
   typedef enum logic [1:0] {
      RP_IDLE = 2'h1,
      RP_ACC = 2'h2
   } chpna_rp_e;
endpackage

// >>> hdl/chpna_ram_if.sv
`timescale 1ns/10ps
`default_nettype none
interface chpna_ram_if;
   import chpna_pkg::*;
   logic req;
   logic we;
   logic [ADDR_W-1:0] addr;
   logic [BYTE_W-1:0] wdata;
   logic ready;
   logic done;
   logic [BYTE_W-1:0] rdata;
   modport master (output req, we, addr, wdata, input ready, done, rdata);
   modport slave (input req, we, addr, wdata, output ready, done, rdata);
endinterface
`default_nettype wire

// >>> hdl/chpna_ram_port.sv
`timescale 1ns/10ps
`default_nettype none
module chpna_ram_port
   import chpna_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   chpna_ram_if.slave ram,
   output logic [ADDR_W-1:0] ram_addr_pins,
   input wire logic [BYTE_W-1:0] ram_data_pins_in,
   output logic [BYTE_W-1:0] ram_data_pins_out,
   output logic ram_data_pins_oe_n,
   output logic ramRd_n,
   output logic ramWr_n
);
   chpna_rp_e state_r;
   logic done_r;
   logic [BYTE_W-1:0] rdata_r;
   logic start;
   logic inAcc;

   // ***********************************************
   // one byte per access: strobe cycle, then release
   // ***********************************************
   // ready held low in the done cycle so a requester never restarts
   assign start = (state_r == RP_IDLE) & ~done_r & ram.req;
   assign inAcc = (state_r == RP_ACC);
   assign ram.ready = (state_r == RP_IDLE) & ~done_r;
   assign ram.done = done_r;
   assign ram.rdata = rdata_r;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_r <= RP_IDLE;
         done_r <= 1'b0;
         rdata_r <= '0;
         ram_addr_pins <= '0;
         ram_data_pins_out <= '0;
         ram_data_pins_oe_n <= 1'b1;
         ramRd_n <= 1'b1;
         ramWr_n <= 1'b1;
      end else begin
         done_r <= inAcc;
         if (start) begin
            state_r <= RP_ACC;
            ram_addr_pins <= ram.addr;
            ram_data_pins_out <= ram.wdata;
            ram_data_pins_oe_n <= ~ram.we;
            ramRd_n <= ram.we;
            ramWr_n <= ~ram.we;
         end else if (inAcc) begin
            state_r <= RP_IDLE;
            rdata_r <= ram_data_pins_in;
            ram_data_pins_oe_n <= 1'b1;
            ramRd_n <= 1'b1;
            ramWr_n <= 1'b1;
         end
      end
   end

   a_wr_strobe_single: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !ramWr_n |-> !ram_data_pins_oe_n ##1 ramWr_n)
      else $error("ram write strobe not a single driven cycle");
   a_addr_stable_acc: assert property (
      @(posedge core_clk) disable iff (!rstn)
      inAcc |-> (ramRd_n ^ ramWr_n) ##1 $stable(ram_addr_pins))
      else $error("ram address moved during access");
endmodule
`default_nettype wire

// >>> verification/chpna_buffer_ram_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***********************************************
// external buffer RAM behind the RAM pins
// ***********************************************
module chpna_buffer_ram_model
   import chpna_pkg::*;
(
   input wire logic core_clk,
   input wire logic [ADDR_W-1:0] ram_addr_pins,
   input wire logic [BYTE_W-1:0] ram_data_pins_out,
   input wire logic ram_data_pins_oe_n,
   input wire logic ramRd_n,
   input wire logic ramWr_n,
   output logic [BYTE_W-1:0] busLevel
);
   logic [BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [BYTE_W-1:0] lastVal;
   // undriven bus shows the inverse of the last driven value, so a late sample never looks valid
   assign busLevel = !ram_data_pins_oe_n ? ram_data_pins_out :
      (!ramRd_n ? mem[ram_addr_pins] : ~lastVal);
   initial begin
      lastVal = 8'h00;
      for (int i = 0; i < (1<<ADDR_W); i++) begin
         mem[i] = 8'h00;
      end
   end
   always @(posedge core_clk) begin
      if (!ram_data_pins_oe_n || !ramRd_n) begin
         lastVal <= busLevel;
      end
      if (!ramWr_n) begin
         mem[ram_addr_pins] <= busLevel;
      end
   end
endmodule
`default_nettype wire

// >>> verification/center_host_port_and_node_areas_bench.sv
`timescale 1ns/10ps
`default_nettype none
module center_host_port_and_node_areas_bench;
   import chpna_pkg::*;
   logic core_clk, rstn, hostDrive, selN, rdN, wrN, handshake, hostOe_n;
   logic swapN, arbEnN, arbIntN, ramOe_n, ramRd_n, ramWr_n, scanEn;
   logic replyValid, cmdValid;
   logic [ADDR_W-1:0] hostAddr, ramAddr;
   logic [DATA_W-1:0] hostData, hostOut, hostBus, replyData, cmdData;
   logic [BYTE_W-1:0] ramIn, ramOut;
   logic [NODE_W-1:0] replyNode, cmdNode;
   logic [CMD_W-1:0] cmdCode;
   int miscompares, comparisons;
   // ***********************************************
   // host side of the data bus
   // ***********************************************
   // released bus shows the inverse of the last host value
   assign hostBus = !hostOe_n ? hostOut : (hostDrive ? hostData : ~hostData);
   chpna_host_port dut (.core_clk(core_clk), .rstn(rstn),
      .host_addr_pins(hostAddr), .host_data_pins_in(hostBus),
      .host_data_pins_out(hostOut), .host_data_pins_oe_n(hostOe_n),
      .host_select_n(selN), .host_read_n(rdN), .host_write_n(wrN),
      .access_handshake(handshake), .byte_order_invert_n(swapN),
      .arbiter_enable_n(arbEnN), .arbiter_internal_sel_n(arbIntN),
      .ram_addr_pins(ramAddr), .ram_data_pins_in(ramIn),
      .ram_data_pins_out(ramOut), .ram_data_pins_oe_n(ramOe_n),
      .ramRd_n(ramRd_n), .ramWr_n(ramWr_n), .scanEnable(scanEn),
      .replyValid(replyValid), .replyNode(replyNode),
      .replyData(replyData), .cmdValid(cmdValid), .cmdNode(cmdNode),
      .cmdCode(cmdCode), .cmdData(cmdData));
   chpna_buffer_ram_model ram (.core_clk(core_clk), .ram_addr_pins(ramAddr),
      .ram_data_pins_out(ramOut), .ram_data_pins_oe_n(ramOe_n),
      .ramRd_n(ramRd_n), .ramWr_n(ramWr_n), .busLevel(ramIn));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // ***********************************************
   // shared tasks
   // ***********************************************
   task automatic tick;
      @(posedge core_clk);
      #10;
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic limit(input int n, input int lim);
      if (n >= lim) begin
         miscompares++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         print_verdict;
      end
   endtask
   task automatic waitHs(input logic lvl);
      int n;
      n = 0;
      while (handshake !== lvl && n < 3000) begin
         tick;
         n++;
      end
      limit(n, 3000);
   endtask
   task automatic hwrite(input logic [10:0] a, input logic [15:0] d);
      hostAddr = a;
      hostData = d;
      hostDrive = 1'b1;
      tick;
      selN = 1'b0;
      wrN = 1'b0;
      waitHs(1'b0);
      tick;
      selN = 1'b1;
      wrN = 1'b1;
      hostDrive = 1'b0; // bus now shows ~d, a late capture gets it wrong
      waitHs(1'b1);
   endtask
   task automatic hread(input logic [10:0] a, input logic [15:0] exp);
      hostAddr = a;
      hostDrive = 1'b0;
      tick;
      selN = 1'b0;
      rdN = 1'b0;
      waitHs(1'b0);
      waitHs(1'b1);
      chk({15'h0000, hostOe_n}, 16'h0000);
      chk(hostBus, exp);
      // strobes still held: no second access may start
      tick;
      chk({15'h0000, handshake}, 16'h0001);
      selN = 1'b1;
      rdN = 1'b1;
      tick;
      tick;
      chk({15'h0000, hostOe_n}, 16'h0001);
   endtask
   task automatic waitCmd(input logic [NODE_W-1:0] node);
      int n;
      n = 0;
      tick;
      while (!(cmdValid === 1'b1 && cmdNode === node) && n < 3000) begin
         tick;
         n++;
      end
      limit(n, 3000);
   endtask
   function automatic logic [15:0] memByte(input logic [10:0] a);
      return {8'h00, ram.mem[a]};
   endfunction
   // plain I/O node, four inputs and twelve outputs by its mode pins
   function automatic logic [15:0] ioNodeReply(input logic [3:0] cmd,
      input logic [15:0] pins);
      if (cmd != 4'h0) begin
         return 16'h0000;
      end
      return {12'h000, pins[3:0]};
   endfunction
   task automatic putReply(input logic [NODE_W-1:0] node,
      input logic [15:0] d, input logic [10:0] a);
      int n;
      replyNode = node;
      replyData = d;
      replyValid = 1'b1;
      tick;
      replyValid = 1'b0;
      n = 0;
      while ({ram.mem[a + 11'h001], ram.mem[a]} !== d && n < 3000) begin
         tick;
         n++;
      end
      limit(n, 3000);
   endtask
   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic scReset;
      chk({15'h0000, handshake}, 16'h0001);
      chk({15'h0000, hostOe_n}, 16'h0001);
      chk({14'h0000, ramRd_n, ramWr_n}, 16'h0003);
      chk({15'h0000, cmdValid}, 16'h0000);
   endtask
   task automatic scWriteRead;
      swapN = 1'b1;
      hwrite(11'h020, 16'hC3A5);
      chk(memByte(11'h020), 16'h00A5);
      chk(memByte(11'h021), 16'h00C3);
      hread(11'h021, 16'hC3A5);
      swapN = 1'b0;
      hread(11'h020, 16'hA5C3);
      hwrite(11'h030, 16'h1E2D);
      chk(memByte(11'h031), 16'h002D);
      chk(memByte(11'h030), 16'h001E);
      swapN = 1'b1;
   endtask
   task automatic scCommands;
      logic [3:0] c;
      scanEn = 1'b1;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         hwrite(11'h088, {4'h9, c, 8'h3C});
         hwrite(11'h008, {8'hF0, 4'h0, c});
         waitCmd(6'h04);
         waitCmd(6'h04);
         chk({12'h000, cmdCode}, {12'h000, c});
         chk(cmdData, {4'h9, c, 8'h3C});
      end
   endtask
   task automatic scReply;
      putReply(6'h04, 16'h7E81, 11'h108);
      hread(11'h108, 16'h7E81);
      waitCmd(6'h05);
      putReply(6'h05, ioNodeReply(cmdCode, 16'hA5A5), 11'h10A);
      hread(11'h10A, 16'h0005);
      waitCmd(6'h04);
      putReply(6'h04, ioNodeReply(cmdCode, 16'hA5A5), 11'h108);
      hread(11'h108, 16'h0000);
      putReply(6'h04, 16'h7E81, 11'h108);
   endtask
   task automatic scArbiter;
      // external enable from host timing gives the host priority over scan
      arbIntN = 1'b1;
      arbEnN = 1'b0;
      hread(11'h108, 16'h7E81);
      arbEnN = 1'b1;
      arbIntN = 1'b0;
      hread(11'h088, 16'h9F3C);
      // both enables off: scan goes first, host waits for a send cycle
      arbIntN = 1'b1;
      hread(11'h108, 16'h7E81);
      arbIntN = 1'b0;
   endtask
   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      miscompares = 0;
      comparisons = 0;
      rstn = 1'b0;
      hostAddr = 11'h000;
      hostData = 16'h0000;
      hostDrive = 1'b0;
      selN = 1'b1;
      rdN = 1'b1;
      wrN = 1'b1;
      swapN = 1'b1;
      arbEnN = 1'b1;
      arbIntN = 1'b0;
      scanEn = 1'b0;
      replyValid = 1'b0;
      replyNode = 6'h00;
      replyData = 16'h0000;
      repeat (RESET_MIN_CLKS) tick;
      rstn = 1'b1;
      tick;
      scReset;
      scWriteRead;
      scCommands;
      scReply;
      scArbiter;
      print_verdict;
   end
endmodule
`default_nettype wire
